// file: rtl/soft_reset_pkg.sv
package soft_reset_pkg;

  // Byte address of the reset control register.
  localparam logic [31:0] RESET_CONTROL_ADDR = 32'h0000_01f8;
  // Byte address of a status register that shows the ready flag and the loader busy flag.
  localparam logic [31:0] RESET_STATUS_ADDR = 32'h0000_01fc;

  // Field positions inside the reset control register.
  localparam int DIGITAL_RESET_POS = 0;
  localparam int PORT_ONE_PHY_RESET_POS = 1;
  localparam int PORT_TWO_PHY_RESET_POS = 2;
  localparam int VIRTUAL_PHY_RESET_POS = 3;

  // Field positions inside the status register.
  localparam int READY_POS = 0;
  localparam int LOADER_BUSY_POS = 1;

  // Reset value of the four self-clearing reset bits.
  localparam logic [3:0] RESET_BITS_INIT = 4'h0;

  // Clock rate in kHz and minimum port PHY hold time in ns.
  localparam int CLOCK_KHZ = 10_000;
  localparam int PHY_HOLD_NS = 102_000;
  // A least time rounds up to whole cycles.
  localparam int PHY_HOLD_CYCLES = (PHY_HOLD_NS * (CLOCK_KHZ / 1000) + 999) / 1000;

  // Cycles that the virtual PHY and the digital core are held in reset.
  localparam int VPHY_HOLD_CYCLES = 4;
  localparam int CORE_HOLD_CYCLES = 8;
  // Cycles the core needs to settle after its reset before ready is raised.
  localparam int SETTLE_CYCLES = 16;

  // Width of the hold counters.
  localparam int HOLD_COUNT_W = 11;

  // AHB transfer type and size encodings used by the slave and the testbench.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [2:0] HSIZE_HALF = 3'h1;

endpackage

// file: rtl/reset_hold_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries one reset request into a hold timer and its state back out.
interface reset_hold_if;
  // Request pulse from the register logic.
  logic start;
  // High while the held unit is in reset.
  logic active;
  // One-cycle pulse when the held unit leaves reset.
  logic done;

  // The register side starts a hold and watches it.
  modport ctrl (output start, input active, input done);
  // The timer side runs the hold.
  modport timer (input start, output active, output done);
endinterface

`default_nettype wire

// file: rtl/reset_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Holds a unit in reset for a fixed count of cycles after a start pulse.
module reset_hold_timer #(
  parameter int HOLD_CYCLES = 4
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Request and state.
  reset_hold_if.timer hold
);

  // Remaining cycles in the hold; zero while idle.
  logic [soft_reset_pkg::HOLD_COUNT_W-1:0] count_reg;
  logic [soft_reset_pkg::HOLD_COUNT_W-1:0] count_next;
  // Pulse when the count reaches its end.
  logic done_reg;
  logic done_next;

  // The count loads on start and runs down; a start while busy is ignored.
  always_comb
  begin
    count_next = count_reg;
    done_next = 1'b0;
    if (count_reg != '0)
    begin
      count_next = count_reg - 1'b1;
      // The last held cycle ends the reset.
      if (count_reg == 1)
      begin
        done_next = 1'b1;
      end
    end
    else if (hold.start)
    begin
      count_next = soft_reset_pkg::HOLD_COUNT_W'(HOLD_CYCLES);
    end
  end

  // Registers the timer state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      done_reg <= done_next;
    end
  end

  // The unit is in reset for the whole count.
  assign hold.active = (count_reg != '0);
  assign hold.done = done_reg;

endmodule

`default_nettype wire

// file: rtl/software_reset_control.sv
// Notes on behaviour
// - Writing one resets the virtual PHY.
// - Virtual PHY bit clears after its reset.
// - Writes to a bit ignored while that bit is set.
// - Port two PHY held at least 102 us.
// - Port one PHY held at least 102 us.
// - Port PHY bits clear when hold ends.
// - Digital reset spares PLL and all PHYs.
// - Loader reload starts after digital reset.
// - Core registers default, sticky bits kept.
// - Digital reset aborts running loader commands.
// - Digital reset bit clears on release.
// - Loader cannot write any reset bit.
// - Reset register readable during reset, not ready.
// - Either halfword readable on its own.
// - Ready stays low until core settles.
`timescale 1ns/1ps
`default_nettype none

module software_reset_control #(
  parameter int PHY_HOLD = soft_reset_pkg::PHY_HOLD_CYCLES,
  parameter int VPHY_HOLD = soft_reset_pkg::VPHY_HOLD_CYCLES,
  parameter int CORE_HOLD = soft_reset_pkg::CORE_HOLD_CYCLES,
  parameter int SETTLE = soft_reset_pkg::SETTLE_CYCLES
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Reset outputs, active low, to the units.
  output logic virtual_phy_resetn,
  output logic port_one_phy_resetn,
  output logic port_two_phy_resetn,
  output logic core_resetn,
  // Configuration loader control.
  output logic loader_abort,
  output logic loader_reload,
  input wire logic loader_busy,
  // Ready flag for the host.
  output logic ready
);

  // Hold timers for the three units and the core.
  reset_hold_if vphy_if();
  reset_hold_if p1_if();
  reset_hold_if p2_if();
  reset_hold_if core_if();

  // Virtual PHY hold; short, since that unit has no analog part to settle.
  reset_hold_timer #(.HOLD_CYCLES(VPHY_HOLD)) vphy_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .hold(vphy_if.timer)
  );
  // Port one PHY hold; the count covers the least hold time at the bus clock.
  reset_hold_timer #(.HOLD_CYCLES(PHY_HOLD)) p1_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .hold(p1_if.timer)
  );
  // Port two PHY hold, the same length as port one.
  reset_hold_timer #(.HOLD_CYCLES(PHY_HOLD)) p2_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .hold(p2_if.timer)
  );
  // Digital core hold; this block itself stays out of that reset.
  reset_hold_timer #(.HOLD_CYCLES(CORE_HOLD)) core_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .hold(core_if.timer)
  );

  // Loader busy is from another domain and passes two flip-flops.
  // Only the second stage is read, so a metastable first stage never reaches logic.
  logic busy_meta_reg;
  logic busy_sync_reg;

  // Captured address phase.
  // Only one transfer is pending at a time, because the slave never inserts wait states.
  logic wr_pend_reg;
  logic wr_pend_next;
  logic rd_pend_reg;
  logic rd_pend_next;
  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  // Size of the captured transfer; a write wider than the bus writes nothing.
  logic [2:0] size_reg;
  logic [2:0] size_next;

  // Self-clearing reset bits, read back in the control register.
  logic [3:0] bits_reg;
  logic [3:0] bits_next;
  // Read data register.
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  // Settle counter after the core reset; ready goes high when it expires.
  logic [soft_reset_pkg::HOLD_COUNT_W-1:0] settle_reg;
  logic [soft_reset_pkg::HOLD_COUNT_W-1:0] settle_next;
  logic ready_reg;
  logic ready_next;
  // One-cycle reload request after the core reset.
  logic reload_reg;
  logic reload_next;

  // Write strobe of the data phase and the write data lanes that carry bits 3:0.
  logic wr_ctl;
  logic [3:0] set_req;

  // Synchroniser for loader busy; the first stage feeds only the second.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_meta_reg <= 1'b0;
      busy_sync_reg <= 1'b0;
    end
    else
    begin
      busy_meta_reg <= loader_busy;
      busy_sync_reg <= busy_meta_reg;
    end
  end

  // Address phase capture; only this slave sits on the bus so hready is its own.
  always_comb
  begin
    wr_pend_next = 1'b0;
    rd_pend_next = 1'b0;
    addr_next = addr_reg;
    size_next = size_reg;
    if (hsel && hready && htrans == soft_reset_pkg::HTRANS_NONSEQ)
    begin
      wr_pend_next = hwrite;
      rd_pend_next = !hwrite;
      addr_next = haddr;
      size_next = hsize;
    end
  end

  // Write of the control register in the data phase; only the bus reaches it.
  // The loader has no path to these bits at all.
  // A size wider than the data bus is no legal transfer and writes nothing.
  assign wr_ctl = wr_pend_reg && addr_reg == soft_reset_pkg::RESET_CONTROL_ADDR &&
                  size_reg <= soft_reset_pkg::HSIZE_WORD;

  // A write of one starts a reset only when that bit is clear.
  assign set_req = wr_ctl ? (hwdata[3:0] & ~bits_reg) : 4'h0;

  // Starts of the hold timers.
  // A start is a single-cycle pulse; the timer ignores it while a hold runs.
  assign vphy_if.start = set_req[soft_reset_pkg::VIRTUAL_PHY_RESET_POS];
  assign p1_if.start = set_req[soft_reset_pkg::PORT_ONE_PHY_RESET_POS];
  assign p2_if.start = set_req[soft_reset_pkg::PORT_TWO_PHY_RESET_POS];
  assign core_if.start = set_req[soft_reset_pkg::DIGITAL_RESET_POS];

  // Bit state: set by an accepted write, cleared when the unit leaves reset.
  // A set and a clear of one bit cannot meet: a start needs it clear, a done needs it set.
  // The bit stays set one cycle past the release, so a write in that cycle is ignored.
  always_comb
  begin
    bits_next = bits_reg | set_req;
    if (vphy_if.done)
    begin
      bits_next[soft_reset_pkg::VIRTUAL_PHY_RESET_POS] = 1'b0;
    end
    if (p1_if.done)
    begin
      bits_next[soft_reset_pkg::PORT_ONE_PHY_RESET_POS] = 1'b0;
    end
    if (p2_if.done)
    begin
      bits_next[soft_reset_pkg::PORT_TWO_PHY_RESET_POS] = 1'b0;
    end
    if (core_if.done)
    begin
      bits_next[soft_reset_pkg::DIGITAL_RESET_POS] = 1'b0;
    end
  end

  // Ready drops with the core reset and rises after the settle count.
  // The settle count also runs after power-up, so ready behaves alike for both resets.
  // The reload is requested once, when the core leaves reset.
  always_comb
  begin
    settle_next = settle_reg;
    ready_next = ready_reg;
    reload_next = 1'b0;
    if (core_if.start || core_if.active)
    begin
      ready_next = 1'b0;
      settle_next = '0;
    end
    else if (core_if.done)
    begin
      settle_next = soft_reset_pkg::HOLD_COUNT_W'(SETTLE);
      reload_next = 1'b1;
    end
    else if (settle_reg != '0)
    begin
      settle_next = settle_reg - 1'b1;
      if (settle_reg == 1)
      begin
        ready_next = 1'b1;
      end
    end
    else if (!ready_reg)
    begin
      // Power-up has no core release to load the count, so an idle count loads here.
      settle_next = soft_reset_pkg::HOLD_COUNT_W'(SETTLE);
    end
  end

  // Read data; this register never waits on ready or the core reset.
  // Either halfword address returns the whole word, with the reset bits in lanes 3:0.
  // Data is taken from next-state values at the address phase, so the data phase already
  // shows a write whose data phase ends on that same edge.
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (rd_pend_next)
    begin
      if (addr_next == soft_reset_pkg::RESET_CONTROL_ADDR ||
          addr_next == soft_reset_pkg::RESET_CONTROL_ADDR + 32'h0000_0002)
      begin
        // Reserved bits 31:4 stay zero.
        rdata_next = {28'h000_0000, bits_next};
      end
      else if (addr_next == soft_reset_pkg::RESET_STATUS_ADDR ||
               addr_next == soft_reset_pkg::RESET_STATUS_ADDR + 32'h0000_0002)
      begin
        // The status word shows ready and the synchronised loader busy flag.
        rdata_next[soft_reset_pkg::READY_POS] = ready_next;
        rdata_next[soft_reset_pkg::LOADER_BUSY_POS] = busy_sync_reg;
      end
    end
    else
    begin
      rdata_next = rdata_reg;
    end
  end

  // Registers all control state.
  // The reset bits are cleared by the async reset; software can only set them.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      size_reg <= soft_reset_pkg::HSIZE_WORD;
      bits_reg <= soft_reset_pkg::RESET_BITS_INIT;
      rdata_reg <= 32'h0000_0000;
      settle_reg <= '0;
      // Ready starts low and rises after a settle period like a digital reset.
      ready_reg <= 1'b0;
      reload_reg <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      size_reg <= size_next;
      bits_reg <= bits_next;
      rdata_reg <= rdata_next;
      settle_reg <= settle_next;
      ready_reg <= ready_next;
      reload_reg <= reload_next;
    end
  end

  // Every transfer is zero wait state and OKAY.
  // No register here needs more than one cycle, so wait states would only cost bandwidth.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // The core reset spares this block, the PLL and the PHY timers, so the
  // register file keeps its sticky bits and the PHYs keep running.
  // The PHY resets come from their own timers, never from the core hold.
  assign core_resetn = !core_if.active;
  assign virtual_phy_resetn = !vphy_if.active;
  assign port_one_phy_resetn = !p1_if.active;
  assign port_two_phy_resetn = !p2_if.active;
  // Abort whatever the loader runs for the whole core reset.
  assign loader_abort = core_if.active;
  assign loader_reload = reload_reg;
  assign ready = ready_reg;

endmodule

`default_nettype wire

// file: sim/software_reset_control_properties.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the reset outputs against the bus writes that cause them.
module software_reset_control_properties #(
  parameter int PHY_HOLD = 20,
  parameter int VPHY_HOLD = 4,
  parameter int CORE_HOLD = 8
) (
  // Clock, reset and bus.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Reset outputs, loader and ready.
  input wire logic virtual_phy_resetn,
  input wire logic port_one_phy_resetn,
  input wire logic port_two_phy_resetn,
  input wire logic core_resetn,
  input wire logic loader_abort,
  input wire logic loader_reload,
  input wire logic ready
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Reset outputs gathered so one counter loop can time them all.
  logic [3:0] rn;
  // Cycles each output has been low; exact hold lengths are judged from it.
  logic [11:0] cnt [4];
  logic [11:0] cnt_next [4];
  // High in the data phase of a write to the control register.
  logic wr_ctl_reg;
  logic wr_ctl_next;
  assign rn = {virtual_phy_resetn, port_two_phy_resetn, port_one_phy_resetn, core_resetn};

  // Next values of the helper state.
  always_comb
  begin
    wr_ctl_next = hsel && hready && htrans == soft_reset_pkg::HTRANS_NONSEQ && hwrite
      && haddr == soft_reset_pkg::RESET_CONTROL_ADDR && hsize <= soft_reset_pkg::HSIZE_WORD;
    for (int i = 0; i < 4; i++)
    begin
      cnt_next[i] = rn[i] ? 12'h000 : cnt[i] + 12'h001;
    end
  end

  // Registers only.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ctl_reg <= 1'b0;
      cnt <= '{default: 12'h000};
    end
    else
    begin
      wr_ctl_reg <= wr_ctl_next;
      cnt <= cnt_next;
    end
  end

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("Bus answer not ready and okay.");
  // The bit stays set one cycle past the release, so that cycle is left out.
  AST_VPHY_START: assert property (
    wr_ctl_reg && hwdata[3] && virtual_phy_resetn && $past(virtual_phy_resetn)
    |=> !virtual_phy_resetn)
    else $error("Virtual PHY reset did not start.");
  AST_PORT_ONE_START: assert property (
    wr_ctl_reg && hwdata[1] && port_one_phy_resetn && $past(port_one_phy_resetn)
    |=> !port_one_phy_resetn)
    else $error("Port one PHY reset did not start.");
  AST_VPHY_HOLD: assert property ($rose(virtual_phy_resetn) |-> cnt[3] == VPHY_HOLD)
    else $error("Virtual PHY hold length wrong.");
  AST_PORT_ONE_HOLD: assert property ($rose(port_one_phy_resetn) |-> cnt[1] == PHY_HOLD)
    else $error("Port one PHY hold length wrong.");
  AST_PORT_TWO_HOLD: assert property ($rose(port_two_phy_resetn) |-> cnt[2] == PHY_HOLD)
    else $error("Port two PHY hold length wrong.");
  AST_CORE_HOLD: assert property ($rose(core_resetn) |-> cnt[0] == CORE_HOLD)
    else $error("Core hold length wrong.");
  AST_PHYS_SPARED: assert property ($fell(core_resetn) |-> $stable(rn[3:1]))
    else $error("Digital reset touched a PHY reset.");
  AST_ABORT: assert property (loader_abort == !core_resetn)
    else $error("Loader abort does not follow core reset.");
  AST_RELOAD: assert property ($rose(core_resetn) |-> ##[0:1] loader_reload)
    else $error("No reload after core reset.");
  AST_RELOAD_PULSE: assert property (loader_reload |=> !loader_reload)
    else $error("Reload longer than one cycle.");
  AST_READY_SETTLE: assert property ($rose(core_resetn) |-> !ready [*8])
    else $error("Ready rose before settling.");
endmodule

bind software_reset_control software_reset_control_properties #(
  .PHY_HOLD(PHY_HOLD),
  .VPHY_HOLD(VPHY_HOLD),
  .CORE_HOLD(CORE_HOLD)
) software_reset_control_properties_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
  .hreadyout, .hresp,
  .virtual_phy_resetn, .port_one_phy_resetn, .port_two_phy_resetn, .core_resetn,
  .loader_abort, .loader_reload, .ready
);

`default_nettype wire

// file: sim/software_reset_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// Drives the reset register over the bus and checks that every reset output drops and is released.
module software_reset_control_tb_top;
  // Design inputs, all valued at time zero.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic loader_busy = 1'b0;
  // Design outputs.
  logic [31:0] hrdata;
  logic hreadyout, hresp, ready, loader_abort, loader_reload;
  logic virtual_phy_resetn, port_one_phy_resetn, port_two_phy_resetn, core_resetn;
  logic [3:0] rn;
  // Counters and the reload catcher.
  int errors = 0;
  int n_compared = 0;
  logic reload_seen = 1'b0;
  assign rn = {virtual_phy_resetn, port_two_phy_resetn, port_one_phy_resetn, core_resetn};

  // A short PHY hold keeps the run brief.
  software_reset_control #(.PHY_HOLD(20)) software_reset_control_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .virtual_phy_resetn, .port_one_phy_resetn,
    .port_two_phy_resetn, .core_resetn, .loader_abort, .loader_reload, .loader_busy, .ready
  );

  always #50 hclk = ~hclk;

  // The reload is a single-cycle pulse, so it is latched here.
  always @(posedge hclk)
  begin
    if (loader_reload === 1'b1)
      reload_seen <= 1'b1;
  end

  task wrap_up;
    $display("Compared %0d, mismatches %0d.", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task bail;
    errors++;
    $display("BAD wait expected done seen timeout");
    wrap_up;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask

  // One edge, then more until ready is sampled high.
  task edge_ready;
    int n;
    @(posedge hclk);
    for (n = 0; hreadyout !== 1'b1; n++)
    begin
      if (n > 50)
        bail;
      @(posedge hclk);
    end
  endtask

  // One single transfer; entered just after a rising edge.
  task bus(input logic w, input logic [2:0] sz, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= soft_reset_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sz;
    haddr <= a;
    edge_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready;
    r = hrdata;
  endtask

  task wr(input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, soft_reset_pkg::HSIZE_WORD, soft_reset_pkg::RESET_CONTROL_ADDR, d, r);
  endtask

  task rd(input logic [2:0] sz, input logic [31:0] a, output logic [31:0] r);
    bus(1'b0, sz, a, 32'h0000_0000, r);
  endtask

  // Reset values, ready, reserved bits and an unmapped place.
  task t_power;
    logic [31:0] r;
    rd(soft_reset_pkg::HSIZE_WORD, soft_reset_pkg::RESET_CONTROL_ADDR, r);
    chk("control at reset", 32'h0000_0000, r);
    r = 32'h0000_0000;
    for (int n = 0; r[0] !== 1'b1; n++)
    begin
      if (n > 60)
        bail;
      rd(soft_reset_pkg::HSIZE_WORD, soft_reset_pkg::RESET_STATUS_ADDR, r);
    end
    chk("ready pin", 32'h0000_0001, {31'h0, ready});
    wr(32'hffff_fff0);
    rd(soft_reset_pkg::HSIZE_WORD, soft_reset_pkg::RESET_CONTROL_ADDR, r);
    chk("reserved bits", 32'h0000_0000, r);
    rd(soft_reset_pkg::HSIZE_WORD, 32'h0000_0100, r);
    chk("unmapped read", 32'h0000_0000, r);
    $display("Power-up test done.");
  endtask

  // Starts one reset bit, retries a port PHY bit while busy and polls until it clears.
  task t_unit(input int b);
    logic [31:0] r;
    logic [2:0] sz;
    reload_seen <= 1'b0;
    wr(32'h0000_0001 << b);
    // The outputs move on the edge that ends the write, so look one edge later.
    @(posedge hclk);
    chk("reset output low", 32'h0000_0000, {31'h0, rn[b]});
    if (b == 0)
      chk("loader abort", 32'h0000_0001, {31'h0, loader_abort});
    // Port two is read a halfword at a time, so each half is seen alone.
    sz = (b == 2) ? soft_reset_pkg::HSIZE_HALF : soft_reset_pkg::HSIZE_WORD;
    rd(sz, soft_reset_pkg::RESET_CONTROL_ADDR, r);
    chk("bit reads set", 32'h0000_0001 << b, {16'h0, r[15:0]});
    if (b == 2)
    begin
      rd(sz, soft_reset_pkg::RESET_CONTROL_ADDR + 32'h0000_0002, r);
      chk("upper half", 32'h0000_0000, {16'h0, r[31:16]});
    end
    if (b == 0)
      chk("ready in reset", 32'h0000_0000, {31'h0, ready});
    // A second start while busy must not stretch the hold.
    if (b == 1 || b == 2)
      wr(32'h0000_0001 << b);
    r = 32'h0000_0001;
    for (int n = 0; r !== 32'h0000_0000; n++)
    begin
      if (n > 100)
        bail;
      rd(soft_reset_pkg::HSIZE_WORD, soft_reset_pkg::RESET_CONTROL_ADDR, r);
    end
    chk("reset output released", 32'h0000_0001, {31'h0, rn[b]});
    if (b == 0)
    begin
      for (int n = 0; ready !== 1'b1; n++)
      begin
        if (n > 60)
          bail;
        @(posedge hclk);
      end
      chk("reload pulse seen", 32'h0000_0001, {31'h0, reload_seen});
    end
    $display("Reset unit %0d test done.", b);
  endtask

  // Loader busy crosses into the status register.
  task t_loader;
    logic [31:0] r;
    loader_busy <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(soft_reset_pkg::HSIZE_WORD, soft_reset_pkg::RESET_STATUS_ADDR, r);
    chk("loader busy", 32'h0000_0001, {31'h0, r[1]});
    loader_busy <= 1'b0;
    $display("Loader test done.");
  endtask

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_power;
    for (int b = 0; b < 4; b++)
      t_unit(b);
    t_loader;
    // A bus reset in mid-hold must leave every bit cleared.
    wr(32'h0000_0002);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk("outputs after bus reset", 32'h0000_000f, {28'h0, rn});
    t_power;
    wrap_up;
  end

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge hclk);
    bail;
  end
endmodule

`default_nettype wire
